// ===== exec_pkg.sv
package exec_pkg;

    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam int OP_W = 5;
    localparam int CNT_W = 4;
    localparam int STACK_DEPTH = 6;
    localparam int SP_W = 3;
    localparam int RAM_DEPTH = 64;
    localparam int RAM_AW = 6;
    localparam int CLOCKS_PER_CYCLE = 4;

    // Data space: program counter low byte and the RAM page
    localparam logic [7:0] PCL_ADDR = 8'h06;
    localparam logic [1:0] RAM_PAGE = 2'h1;

    // APB register byte offsets
    localparam logic [11:0] OFF_INSTR = 12'h000;
    localparam logic [11:0] OFF_ACC = 12'h004;
    localparam logic [11:0] OFF_FLAGS = 12'h008;
    localparam logic [11:0] OFF_PC = 12'h00C;
    localparam logic [11:0] OFF_WDT = 12'h010;
    localparam logic [11:0] OFF_MADDR = 12'h014;
    localparam logic [11:0] OFF_MDATA = 12'h018;
    localparam logic [11:0] OFF_STACK = 12'h01C;

    // Instruction word fields
    localparam int INSTR_OP_LSB = 0;
    localparam int INSTR_OPD_LSB = 8;
    localparam int INSTR_JA_LSB = 16;

    // Flag register bit positions
    localparam int FB_C = 0;
    localparam int FB_AC = 1;
    localparam int FB_Z = 2;
    localparam int FB_EMI = 5;
    localparam int FB_WAKE = 10;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 11'h000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_MAX = 8'hFF;

    // Decimal adjust constants
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_ADJ = 4'h6;

    typedef enum logic [OP_W-1:0] {
        OP_NOP = 5'h00,
        OP_PRECLR1 = 5'h01,
        OP_PRECLR2 = 5'h02,
        OP_CPL = 5'h03,
        OP_COMPLEMENT_TO_ACCUMULATOR = 5'h04,
        OP_DAA = 5'h05,
        OP_DEC = 5'h06,
        OP_DECREMENT_TO_ACCUMULATOR = 5'h07,
        OP_INC = 5'h08,
        OP_INCREMENT_TO_ACCUMULATOR = 5'h09,
        OP_HALT = 5'h0A,
        OP_JMP = 5'h0B,
        OP_MOV_AM = 5'h0C,
        OP_MOV_AX = 5'h0D,
        OP_MOV_MA = 5'h0E,
        OP_OR_AM = 5'h0F,
        OP_OR_AX = 5'h10,
        OP_ORM = 5'h11,
        OP_RET = 5'h12,
        OP_RET_AX = 5'h13,
        OP_RETURN_FROM_INTERRUPT = 5'h14,
        OP_RL = 5'h15,
        OP_RLA = 5'h16
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_HALT = 2'h3
    } exec_state_t;

endpackage

// ===== exec_unit.sv
// Overview of operation
// - Both preclears executed: watchdog zeroed, sleep cleared, timeout cleared unless the watchdog wraps in that clock
// - One preclear alone only records itself; watchdog keeps counting, sleep and timeout not cleared
// - Complement memory: byte becomes its ones complement, zero flag updated
// - Complement to accumulator: memory kept, zero flag updated
// - Decimal adjust low nibble plus 6 if above 9 or half carry
// - High nibble plus carry-in; above 9 or carry adds 6, sets carry
// - Decimal adjust result goes to memory; only carry may change
// - Decrement to memory or accumulator; only zero flag updated
// - Increment to memory or accumulator; only zero flag updated
// - Halt: pc plus one, stop, watchdog cleared, sleep set, timeout cleared unless the watchdog wraps in that clock
// - Jump loads pc from the instruction address, no flags
// - Move immediate loads accumulator with constant, no flags
// - Move from memory copies byte to accumulator, no flags
// - Move to memory copies accumulator to byte, no flags
// - No-operation only advances the program counter by one
// - OR forms combine accumulator with byte or constant, zero flag only
// - Return pops pc from the stack, takes two instruction cycles
// - Return with constant pops pc and loads accumulator
// - Return from interrupt pops pc and sets the master interrupt enable
// - Rotate left memory: bit 7 wraps to bit 0, no flags
// - Rotate left to accumulator: memory and flags unchanged
// - Writing the pc low byte adds one instruction cycle of four clocks
//
// The APB register port and the register offsets were decided locally.
module exec_unit import exec_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic master_irq_enable,
    output logic sleep_flag,
    output logic timeout_flag,
    output logic cpu_halted
);

    exec_state_t state_q;
    logic [OP_W-1:0] ir_op_q;
    logic [7:0] ir_opd_q;
    logic [PC_W-1:0] ir_ja_q;
    logic [CNT_W-1:0] cnt_q;
    logic [7:0] acc_q;
    logic [PC_W-1:0] pc_q;
    logic c_q, ac_q, z_q, to_q, sleep_q, emi_q, pre1_q, pre2_q;
    logic [7:0] wdt_q, presc_q, maddr_q;
    logic [7:0] ram_q [RAM_DEPTH];
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [31:0] prdata_q;

    logic busy_w, halted_w, access_w, hit_w, err_w, wr_w, start_w, commit_w;
    logic ir_is_pcl, ir_is_ram, ma_is_pcl, ma_is_ram, stack_full_w;
    logic [7:0] src_w, mdata_w;
    logic [SP_W-1:0] top_w;
    logic [OP_W-1:0] new_op_w;
    logic new_ret_w, new_pcl_w;
    logic [CNT_W-1:0] len_w;

    logic [7:0] res_w;
    logic to_acc_w, to_mem_w, upd_z_w, pop_w, set_emi_w, c_n_w;
    logic [PC_W-1:0] new_pc_w;
    logic [4:0] lo_sum_w, hi_sum_w;
    logic ac1_w, daa_c_w;
    logic [3:0] hi_res_w;
    logic wdt_wrap_w, pair_clear_w;

    function automatic logic op_writes_mem(input logic [OP_W-1:0] op);
        case (op)
            OP_CPL, OP_DAA, OP_DEC, OP_INC, OP_MOV_MA, OP_ORM, OP_RL:
                op_writes_mem = 1'b1;
            default: op_writes_mem = 1'b0;
        endcase
    endfunction

    function automatic logic op_is_ret(input logic [OP_W-1:0] op);
        op_is_ret = (op == OP_RET) || (op == OP_RET_AX) || (op == OP_RETURN_FROM_INTERRUPT);
    endfunction

    assign busy_w = (state_q == ST_EXEC);
    assign halted_w = (state_q == ST_HALT);
    assign commit_w = busy_w && (cnt_q == '0);
    assign access_w = psel && penable;
    assign stack_full_w = (sp_q == SP_W'(STACK_DEPTH));
    assign top_w = (sp_q == '0) ? '0 : sp_q - SP_W'(1);

    // APB decode: zero wait states, writes refused while executing
    always_comb begin
        case (paddr)
            OFF_INSTR, OFF_ACC, OFF_FLAGS, OFF_PC, OFF_WDT, OFF_MADDR,
            OFF_MDATA, OFF_STACK: hit_w = 1'b1;
            default: hit_w = 1'b0;
        endcase
        err_w = !hit_w;
        if (pwrite && (busy_w || paddr == OFF_WDT)) begin
            err_w = 1'b1;
        end
        if (pwrite && paddr == OFF_INSTR && halted_w) begin
            err_w = 1'b1;
        end
        if (pwrite && paddr == OFF_STACK && stack_full_w) begin
            err_w = 1'b1;
        end
    end

    assign wr_w = access_w && pwrite && !err_w;
    assign start_w = wr_w && (paddr == OFF_INSTR);
    assign pready = 1'b1;
    assign pslverr = access_w && err_w;
    assign prdata = prdata_q;
    assign master_irq_enable = emi_q;
    assign sleep_flag = sleep_q;
    assign timeout_flag = to_q;
    assign cpu_halted = halted_w;

    // Data space read for the instruction operand and the software window
    assign ir_is_pcl = (ir_opd_q == PCL_ADDR);
    assign ir_is_ram = (ir_opd_q[7:6] == RAM_PAGE);
    assign ma_is_pcl = (maddr_q == PCL_ADDR);
    assign ma_is_ram = (maddr_q[7:6] == RAM_PAGE);
    assign src_w = ir_is_pcl ? pc_q[7:0] :
                   ir_is_ram ? ram_q[ir_opd_q[RAM_AW-1:0]] : BYTE_ZERO;
    assign mdata_w = ma_is_pcl ? pc_q[7:0] :
                     ma_is_ram ? ram_q[maddr_q[RAM_AW-1:0]] : BYTE_ZERO;

    // Instruction length in clocks minus one, fixed when the instruction is taken
    assign new_op_w = pwdata[INSTR_OP_LSB +: OP_W];
    assign new_ret_w = op_is_ret(new_op_w);
    assign new_pcl_w = op_writes_mem(new_op_w) &&
                       (pwdata[INSTR_OPD_LSB +: 8] == PCL_ADDR);
    assign len_w = CNT_W'(CLOCKS_PER_CYCLE *
                   (1 + int'(new_ret_w) + int'(new_pcl_w)) - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_w) begin
                        state_q <= ST_EXEC;
                        cnt_q <= len_w;
                    end
                end
                ST_EXEC: begin
                    if (commit_w) begin
                        state_q <= (ir_op_q == OP_HALT) ? ST_HALT
                                                        : ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                ST_HALT: begin
                    if (wr_w && paddr == OFF_FLAGS && pwdata[FB_WAKE]) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_op_q <= OP_NOP;
            ir_opd_q <= BYTE_ZERO;
            ir_ja_q <= PC_RST;
        end else if (start_w) begin
            ir_op_q <= new_op_w;
            ir_opd_q <= pwdata[INSTR_OPD_LSB +: 8];
            ir_ja_q <= pwdata[INSTR_JA_LSB +: PC_W];
        end
    end

    // Decimal adjust datapath
    always_comb begin
        if (acc_q[3:0] > BCD_MAX || ac_q) begin
            lo_sum_w = {1'b0, acc_q[3:0]} + {1'b0, BCD_ADJ};
            ac1_w = !ac_q;
        end else begin
            lo_sum_w = {1'b0, acc_q[3:0]};
            ac1_w = 1'b0;
        end
        hi_sum_w = {1'b0, acc_q[7:4]} + {4'h0, ac1_w};
        if (hi_sum_w > {1'b0, BCD_MAX} || c_q) begin
            hi_res_w = hi_sum_w[3:0] + BCD_ADJ;
            daa_c_w = 1'b1;
        end else begin
            hi_res_w = hi_sum_w[3:0];
            daa_c_w = c_q;
        end
    end

    // Execute datapath, applied at the commit clock
    always_comb begin
        res_w = acc_q;
        to_acc_w = 1'b0;
        to_mem_w = 1'b0;
        upd_z_w = 1'b0;
        pop_w = 1'b0;
        set_emi_w = 1'b0;
        c_n_w = c_q;
        new_pc_w = pc_q + PC_W'(1);
        case (ir_op_q)
            OP_CPL: begin
                res_w = ~src_w;
                to_mem_w = 1'b1;
                upd_z_w = 1'b1;
            end
            OP_COMPLEMENT_TO_ACCUMULATOR: begin
                res_w = ~src_w;
                to_acc_w = 1'b1;
                upd_z_w = 1'b1;
            end
            OP_DAA: begin
                res_w = {hi_res_w, lo_sum_w[3:0]};
                to_mem_w = 1'b1;
                c_n_w = daa_c_w;
            end
            OP_DEC, OP_DECREMENT_TO_ACCUMULATOR: begin
                res_w = src_w - BYTE_ONE;
                to_mem_w = (ir_op_q == OP_DEC);
                to_acc_w = (ir_op_q == OP_DECREMENT_TO_ACCUMULATOR);
                upd_z_w = 1'b1;
            end
            OP_INC, OP_INCREMENT_TO_ACCUMULATOR: begin
                res_w = src_w + BYTE_ONE;
                to_mem_w = (ir_op_q == OP_INC);
                to_acc_w = (ir_op_q == OP_INCREMENT_TO_ACCUMULATOR);
                upd_z_w = 1'b1;
            end
            OP_JMP: new_pc_w = ir_ja_q;
            OP_MOV_AM: begin
                res_w = src_w;
                to_acc_w = 1'b1;
            end
            OP_MOV_AX: begin
                res_w = ir_opd_q;
                to_acc_w = 1'b1;
            end
            OP_MOV_MA: begin
                res_w = acc_q;
                to_mem_w = 1'b1;
            end
            OP_OR_AM, OP_ORM: begin
                res_w = acc_q | src_w;
                to_acc_w = (ir_op_q == OP_OR_AM);
                to_mem_w = (ir_op_q == OP_ORM);
                upd_z_w = 1'b1;
            end
            OP_OR_AX: begin
                res_w = acc_q | ir_opd_q;
                to_acc_w = 1'b1;
                upd_z_w = 1'b1;
            end
            OP_RET, OP_RET_AX, OP_RETURN_FROM_INTERRUPT: begin
                new_pc_w = stack_q[top_w];
                pop_w = 1'b1;
                res_w = ir_opd_q;
                to_acc_w = (ir_op_q == OP_RET_AX);
                set_emi_w = (ir_op_q == OP_RETURN_FROM_INTERRUPT);
            end
            OP_RL, OP_RLA: begin
                res_w = {src_w[6:0], src_w[7]};
                to_mem_w = (ir_op_q == OP_RL);
                to_acc_w = (ir_op_q == OP_RLA);
            end
            default: res_w = acc_q;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= ACC_RST;
        end else if (commit_w && to_acc_w) begin
            acc_q <= res_w;
        end else if (wr_w && paddr == OFF_ACC) begin
            acc_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_q <= 1'b0;
            ac_q <= 1'b0;
            z_q <= 1'b0;
            emi_q <= 1'b0;
        end else if (commit_w) begin
            c_q <= c_n_w;
            if (upd_z_w) begin
                z_q <= (res_w == BYTE_ZERO);
            end
            if (set_emi_w) begin
                emi_q <= 1'b1;
            end
        end else if (wr_w && paddr == OFF_FLAGS) begin
            c_q <= pwdata[FB_C];
            ac_q <= pwdata[FB_AC];
            z_q <= pwdata[FB_Z];
            emi_q <= pwdata[FB_EMI];
        end
    end

    // Watchdog count, timeout and sleep flags, preclear pairing
    assign wdt_wrap_w = !halted_w && presc_q == BYTE_MAX && wdt_q == BYTE_MAX;
    assign pair_clear_w = commit_w &&
        ((ir_op_q == OP_PRECLR1 && pre2_q) ||
         (ir_op_q == OP_PRECLR2 && pre1_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_q <= BYTE_ZERO;
            presc_q <= BYTE_ZERO;
            to_q <= 1'b0;
            sleep_q <= 1'b0;
            pre1_q <= 1'b0;
            pre2_q <= 1'b0;
        end else if (pair_clear_w || (commit_w && ir_op_q == OP_HALT)) begin
            wdt_q <= BYTE_ZERO;
            presc_q <= BYTE_ZERO;
            to_q <= wdt_wrap_w;
            sleep_q <= (ir_op_q == OP_HALT);
            pre1_q <= 1'b0;
            pre2_q <= 1'b0;
        end else begin
            if (commit_w && ir_op_q == OP_PRECLR1) begin
                pre1_q <= 1'b1;
            end
            if (commit_w && ir_op_q == OP_PRECLR2) begin
                pre2_q <= 1'b1;
            end
            if (!halted_w) begin
                presc_q <= presc_q + BYTE_ONE;
                if (presc_q == BYTE_MAX) begin
                    wdt_q <= wdt_q + BYTE_ONE;
                end
            end
            if (wdt_wrap_w) begin
                to_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= PC_RST;
        end else if (commit_w && to_mem_w && ir_is_pcl) begin
            pc_q <= {pc_q[PC_W-1:8], res_w};
        end else if (commit_w) begin
            pc_q <= new_pc_w;
        end else if (wr_w && paddr == OFF_PC) begin
            pc_q <= pwdata[PC_W-1:0];
        end else if (wr_w && paddr == OFF_MDATA && ma_is_pcl) begin
            pc_q <= {pc_q[PC_W-1:8], pwdata[7:0]};
        end
    end

    generate
        for (genvar i = 0; i < RAM_DEPTH; i++) begin : g_ram
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ram_q[i] <= BYTE_ZERO;
                end else if (commit_w && to_mem_w && ir_is_ram &&
                             ir_opd_q[RAM_AW-1:0] == RAM_AW'(i)) begin
                    ram_q[i] <= res_w;
                end else if (wr_w && paddr == OFF_MDATA && ma_is_ram &&
                             maddr_q[RAM_AW-1:0] == RAM_AW'(i)) begin
                    ram_q[i] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= '0;
            for (int k = 0; k < STACK_DEPTH; k++) begin
                stack_q[k] <= PC_RST;
            end
        end else if (commit_w && pop_w) begin
            sp_q <= top_w;
        end else if (wr_w && paddr == OFF_STACK) begin
            stack_q[sp_q] <= pwdata[PC_W-1:0];
            sp_q <= sp_q + SP_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            maddr_q <= BYTE_ZERO;
        end else if (wr_w && paddr == OFF_MADDR) begin
            maddr_q <= pwdata[7:0];
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (psel && !penable) begin
            case (paddr)
                OFF_INSTR: prdata_q <= {5'h00, ir_ja_q, ir_opd_q, 3'h0,
                    ir_op_q};
                OFF_ACC: prdata_q <= {24'h000000, acc_q};
                OFF_FLAGS: prdata_q <= {21'h000000, 1'b0, halted_w, busy_w,
                    pre2_q, pre1_q, emi_q, sleep_q, to_q, z_q, ac_q, c_q};
                OFF_PC: prdata_q <= {21'h000000, pc_q};
                OFF_WDT: prdata_q <= {24'h000000, wdt_q};
                OFF_MADDR: prdata_q <= {24'h000000, maddr_q};
                OFF_MDATA: prdata_q <= {24'h000000, mdata_w};
                OFF_STACK: prdata_q <= {29'h00000000, sp_q};
                default: prdata_q <= '0;
            endcase
        end
    end

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_quiet7;
        (!commit_w) [*7];
    endsequence

    a_preclear_pair: assert property (
        pair_clear_w && !wdt_wrap_w
        |=> wdt_q == BYTE_ZERO && !to_q && !sleep_q)
        else $error("paired preclear did not clear watchdog state");
    a_preclear_single: assert property (
        commit_w && ir_op_q == OP_PRECLR1 && !pre2_q && !wdt_wrap_w
        |=> pre1_q && $stable(to_q) && $stable(sleep_q))
        else $error("single preclear changed flags");
    a_complement_to_accumulator_result: assert property (
        commit_w && ir_op_q == OP_COMPLEMENT_TO_ACCUMULATOR |=> acc_q == ~$past(src_w)
        && z_q == (acc_q == BYTE_ZERO) && $stable(c_q))
        else $error("complement to accumulator wrong");
    a_daa_carry: assert property (
        commit_w && ir_op_q == OP_DAA && c_q |=> c_q && $stable(z_q))
        else $error("decimal adjust lost carry");
    a_inc_zero: assert property (
        commit_w && ir_op_q == OP_INCREMENT_TO_ACCUMULATOR
        |=> acc_q == $past(src_w) + BYTE_ONE && z_q == (acc_q == BYTE_ZERO))
        else $error("increment result or zero flag wrong");
    a_halt_state: assert property (
        commit_w && ir_op_q == OP_HALT && !wdt_wrap_w
        |=> cpu_halted && sleep_q && !to_q && wdt_q == BYTE_ZERO
        && pc_q == $past(pc_q) + PC_W'(1))
        else $error("halt did not enter power down state");
    a_jump_target: assert property (
        commit_w && ir_op_q == OP_JMP |=> pc_q == $past(ir_ja_q))
        else $error("jump target not loaded");
    a_nop_pc: assert property (
        commit_w && ir_op_q == OP_NOP
        |=> pc_q == $past(pc_q) + PC_W'(1) && $stable(acc_q))
        else $error("no-operation changed state");
    a_ret_length: assert property (
        start_w && new_ret_w |=> s_quiet7 ##1 commit_w)
        else $error("return did not take two instruction cycles");
    a_pcl_stretch: assert property (
        start_w && new_pcl_w && !new_ret_w |=> s_quiet7 ##1 commit_w)
        else $error("pc low byte write not stretched");
    a_return_from_interrupt_enable: assert property (
        commit_w && ir_op_q == OP_RETURN_FROM_INTERRUPT |=> master_irq_enable)
        else $error("return from interrupt left interrupts off");
    a_rla_rotate: assert property (
        commit_w && ir_op_q == OP_RLA
        |=> acc_q == {$past(src_w[6:0]), $past(src_w[7])} && $stable(z_q))
        else $error("rotate left to accumulator wrong");

endmodule // exec_unit

// ===== mcu_instruction_execute_subset_tb_top.sv
module mcu_instruction_execute_subset_tb_top import exec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq_en, sleep, tmo, halted;
    int mismatches = 0;
    int checks = 0;
    int polls;
    int n;
    logic [7:0] st = 8'h40;
    logic [7:0] a, m, x;
    logic [31:0] rv;
    logic err;
    op_t ops [16] = '{OP_NOP, OP_CPL, OP_COMPLEMENT_TO_ACCUMULATOR, OP_DAA, OP_DEC, OP_DECREMENT_TO_ACCUMULATOR,
        OP_INC, OP_INCREMENT_TO_ACCUMULATOR, OP_MOV_AM, OP_MOV_AX, OP_MOV_MA, OP_OR_AM,
        OP_OR_AX, OP_ORM, OP_RL, OP_RLA};

    always #20 pclk = ~pclk;

    exec_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .master_irq_enable(irq_en),
        .sleep_flag(sleep), .timeout_flag(tmo), .cpu_halted(halted));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Expected {flags, memory, accumulator} after one instruction
    function automatic logic [18:0] model(input op_t op,
        input logic [7:0] a, m, x, input logic [2:0] f);
        logic [7:0] na, nm;
        logic [2:0] nf;
        logic [3:0] lo;
        logic [4:0] hi;
        logic ac1;
        na = a;
        nm = m;
        nf = f;
        case (op)
            OP_CPL: nm = ~m;
            OP_COMPLEMENT_TO_ACCUMULATOR: na = ~m;
            OP_DEC: nm = m - 8'h01;
            OP_DECREMENT_TO_ACCUMULATOR: na = m - 8'h01;
            OP_INC: nm = m + 8'h01;
            OP_INCREMENT_TO_ACCUMULATOR: na = m + 8'h01;
            OP_MOV_AM: na = m;
            OP_MOV_AX: na = x;
            OP_MOV_MA: nm = a;
            OP_OR_AM: na = a | m;
            OP_OR_AX: na = a | x;
            OP_ORM: nm = a | m;
            OP_RL: nm = {m[6:0], m[7]};
            OP_RLA: na = {m[6:0], m[7]};
            OP_DAA: begin
                lo = a[3:0];
                ac1 = 1'b0;
                if (a[3:0] > 4'h9 || f[1]) begin
                    lo = a[3:0] + 4'h6;
                    ac1 = ~f[1];
                end
                hi = {1'b0, a[7:4]} + {4'h0, ac1};
                if (hi > 5'h09 || f[0]) begin
                    hi = hi + 5'h06;
                    nf[0] = 1'b1;
                end
                nm = {hi[3:0], lo};
            end
            default: ;
        endcase
        if (op inside {OP_CPL, OP_DEC, OP_INC, OP_ORM})
            nf[2] = (nm == 8'h00);
        if (op inside {OP_COMPLEMENT_TO_ACCUMULATOR, OP_DECREMENT_TO_ACCUMULATOR, OP_INCREMENT_TO_ACCUMULATOR, OP_OR_AM, OP_OR_AX})
            nf[2] = (na == 8'h00);
        return {nf, nm, na};
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50)
            chk("pready", 0, 1);
    endtask

    task automatic rc(input string nm, input logic [11:0] ad,
        input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(nm, rv, e);
    endtask

    task automatic exec(input op_t op, input logic [7:0] opd,
        input logic [10:0] ja);
        apb(1'b1, OFF_INSTR, {5'h00, ja, opd, 3'h0, op});
        polls = 0;
        do begin
            apb(1'b0, OFF_FLAGS, 32'h0);
            polls++;
        end while (rv[8] !== 1'b0 && polls < 20);
        chk("busy", {31'h0, rv[8]}, 0);
    endtask

    task automatic trial(input op_t op, input logic [7:0] a, m, x,
        input logic [2:0] f);
        logic [18:0] e;
        logic [10:0] pc;
        e = model(op, a, m, x, f);
        apb(1'b1, OFF_FLAGS, {29'h0, f});
        apb(1'b1, OFF_ACC, {24'h0, a});
        apb(1'b1, OFF_MADDR, {24'h0, RAM_PAGE, x[5:0]});
        apb(1'b1, OFF_MDATA, {24'h0, m});
        apb(1'b0, OFF_PC, 32'h0);
        pc = rv[10:0];
        exec(op, (op inside {OP_MOV_AX, OP_OR_AX}) ? x : {RAM_PAGE, x[5:0]},
            11'h000);
        rc("acc", OFF_ACC, {24'h0, e[7:0]});
        rc("mem", OFF_MDATA, {24'h0, e[15:8]});
        apb(1'b0, OFF_FLAGS, 32'h0);
        chk("flags", {29'h0, rv[2:0]},
            {29'h0, e[18:16]});
        rc("pc", OFF_PC, {21'h0, pc + 11'h001});
    endtask

    initial begin
        repeat (30000) @(posedge pclk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        trial(OP_INC, 8'h00, 8'hFF, 8'h40, 3'h0);
        trial(OP_DECREMENT_TO_ACCUMULATOR, 8'h00, 8'h01, 8'h41, 3'h7);
        trial(OP_DAA, 8'h9A, 8'h00, 8'h42, 3'h0);
        trial(OP_DAA, 8'h3C, 8'h00, 8'h43, 3'h2);
        trial(OP_DAA, 8'h12, 8'h00, 8'h45, 3'h1);
        trial(OP_RL, 8'h00, 8'h80, 8'h44, 3'h5);
        for (int i = 0; i < 48; i++) begin
            st = lfsr(st);
            a = st;
            st = lfsr(st);
            m = st;
            st = lfsr(st);
            x = st;
            st = lfsr(st);
            trial(ops[st[3:0]], a, m, x, st[6:4]);
        end
        apb(1'b0, OFF_PC, 32'h0);
        n = int'(rv[10:0]);
        exec(OP_HALT, 8'h00, 11'h000);
        chk("halt", {halted, sleep, tmo}, 3'h6);
        rc("wdt", OFF_WDT, 32'h0);
        rc("pc", OFF_PC, {21'h0, 11'(n + 1)});
        apb(1'b1, OFF_INSTR, 32'h0);
        chk("instr_refused", err, 1);
        apb(1'b1, OFF_FLAGS, 32'h400);
        apb(1'b0, OFF_FLAGS, 32'h0);
        chk("woken", halted, 0);
        chk("woken_flag", {31'h0, rv[9]}, 0);
        exec(OP_PRECLR1, 8'h00, 11'h000);
        apb(1'b0, OFF_FLAGS, 32'h0);
        chk("one_preclear", {sleep, rv[7:3]}, 6'h2A);
        exec(OP_PRECLR2, 8'h00, 11'h000);
        apb(1'b0, OFF_FLAGS, 32'h0);
        chk("both_preclear", {sleep, rv[7:3]}, 6'h00);
        rc("wdt", OFF_WDT, 32'h0);
        apb(1'b1, OFF_STACK, 32'h123);
        apb(1'b1, OFF_STACK, 32'h345);
        apb(1'b1, OFF_STACK, 32'h2AB);
        exec(OP_RETURN_FROM_INTERRUPT, 8'h00, 11'h000);
        chk("irq_en", irq_en, 1);
        rc("pc", OFF_PC, 32'h2AB);
        exec(OP_RET_AX, 8'h5A, 11'h000);
        rc("acc", OFF_ACC, 32'h5A);
        exec(OP_NOP, 8'h00, 11'h000);
        n = polls;
        exec(OP_RET, 8'h00, 11'h000);
        chk("ret_len", polls >= n + 2, 1);
        rc("pc", OFF_PC, 32'h123);
        exec(OP_JMP, 8'h00, 11'h5A5);
        rc("pc", OFF_PC, 32'h5A5);
        exec(OP_MOV_AX, 8'h33, 11'h000);
        exec(OP_MOV_MA, PCL_ADDR, 11'h000);
        rc("pc", OFF_PC, 32'h533);
        apb(1'b1, 12'h020, 32'h0);
        chk("unmapped", err, 1);
        tally_and_finish();
    end
endmodule // mcu_instruction_execute_subset_tb_top
